// *** core/wdg_regs.svh ***
// constants for the watchdog failure tally block
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH
`define CFG_WATCHDOG_RESET_PERMIT_BIT 3
`define CFG_QA_MODE_BIT 5
`define STAT_NO_RESPONSE_BIT 1
`define STAT_EARLY_BIT 2
`define TALLY_INIT 3'h5
`define TALLY_MAX 3'h7
`define TALLY_OUT_OF_RANGE 3'h5
`define PULSE_MIN_NS 32000
`define CLK_PERIOD_NS 50
`define PULSE_MIN_CYC ((`PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_NS 550000
`define STEP_CYC (`STEP_NS / `CLK_PERIOD_NS)
`endif

// *** core/wdg_pkg.sv ***
// types for the watchdog failure tally block
package wdg_pkg;
  typedef enum logic [1:0] {
    DEV_RESET = 2'b00,
    DEV_DIAG = 2'b01,
    DEV_ACTIVE = 2'b10,
    DEV_SAFE = 2'b11
  } dev_state_e;
  typedef enum logic [1:0] {
    WIN_CLOSED = 2'b00,
    WIN_OPEN = 2'b01
  } win_state_e;
endpackage : wdg_pkg

// *** core/trigger_filter.sv ***
// trigger pulse qualifier: rising edge then falling edge after min high time
`timescale 1ns/100ps
`include "wdg_regs.svh"
module trigger_filter #(
  parameter int MIN_CYC = `PULSE_MIN_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // trigger pin and result
  input wire logic trig_i,
  output logic trigger_o
);
  initial begin
    if (MIN_CYC < 1) $error("MIN_CYC must be at least 1");
    if (MIN_CYC > 65534) $error("MIN_CYC must fit the high-time counter");
  end
  logic prev_q;
  logic [15:0] high_cnt_q;
  logic trig_q;

  // count high time since rising edge
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prev_q <= 1'b0;
      high_cnt_q <= 16'h0000;
    end else begin
      prev_q <= trig_i;
      if (trig_i && !prev_q) high_cnt_q <= 16'h0001;
      else if (trig_i && high_cnt_q != 16'hffff) high_cnt_q <= high_cnt_q + 16'h0001;
    end
  end

  // qualify on falling edge, longer than the minimum
  always_ff @(posedge clock_i) begin
    if (srst_i) trig_q <= 1'b0;
    else trig_q <= !trig_i && prev_q && (high_cnt_q > 16'(MIN_CYC)); // [RULE18]
  end
  assign trigger_o = trig_q;
endmodule : trigger_filter

// *** core/window_timer.sv ***
// closed/open window sequencer, counts 0.55 ms steps
`timescale 1ns/100ps
`include "wdg_regs.svh"
module window_timer
  import wdg_pkg::*;
#(
  parameter int STEP_CYC = `STEP_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // control
  input wire logic restart_i,
  input wire logic [6:0] win1_steps_i,
  input wire logic [4:0] win2_steps_i,
  // status
  output logic open_o,
  output logic timeout_o
);
  initial begin
    if (STEP_CYC < 1) $error("STEP_CYC must be at least 1");
  end
  win_state_e win_q;
  logic [31:0] pre_q;
  logic [6:0] steps_q;
  logic tick;
  logic to_q;
  assign tick = (pre_q == 32'(STEP_CYC - 1));

  // step prescaler
  always_ff @(posedge clock_i) begin
    if (srst_i || restart_i || tick) pre_q <= 32'h0;
    else pre_q <= pre_q + 32'h1;
  end

  // window sequence
  always_ff @(posedge clock_i) begin
    to_q <= 1'b0;
    if (srst_i || restart_i) begin
      win_q <= WIN_CLOSED;
      steps_q <= 7'h00;
    end else if (tick) begin
      case (win_q)
        WIN_CLOSED: begin
          if (steps_q + 7'h01 >= win1_steps_i) begin
            win_q <= WIN_OPEN;
            steps_q <= 7'h00;
          end else steps_q <= steps_q + 7'h01;
        end
        default: begin
          if (steps_q >= {2'b00, win2_steps_i}) begin
            win_q <= WIN_CLOSED;
            steps_q <= 7'h00;
            to_q <= 1'b1;
          end else steps_q <= steps_q + 7'h01;
        end
      endcase
    end
  end
  assign open_o = (win_q == WIN_OPEN);
  assign timeout_o = to_q;
endmodule : window_timer

// *** core/mcu_watchdog_fail_counter.sv ***
// watchdog supervision: failure tally, drive enable and mcu reset
// ----------------------------------------------------------------
// Summary of operation
// (RULE1) misbehaving mcu forces drive enable low
// (RULE2) reset to diagnostic starts trigger mode
// (RULE3) trigger mode events arrive as pin pulses
// (RULE4) qa mode answers arrive over spi
// (RULE5) qa mode selectable only in diagnostic
// (RULE6) lockstep monitor unused in trigger mode
// (RULE7) three-bit tally: up bad, down good
// (RULE8) tally five or more: out of range
// (RULE9) tally four or less: in range, permit
// (RULE10) tally ignores watchdog reset permit
// (RULE11) good event decrements, floor zero
// (RULE12) bad event increments, ceiling seven
// (RULE13) timeout increments, sets no-response flag (here the flag is not set while an spi frame is open)
// (RULE14) load five entering diagnostic or active
// (RULE15) seven plus bad with permit: reset
// (RULE16) in reset, tally reloads five
// (RULE17) seven when permit set: immediate reset
// (RULE18) trigger: rise then fall over 32 us
// (RULE19) closed-window trigger is bad, early flag
// (RULE20) open-window trigger is good, restarts
// (RULE21) one update per event; reinit wins
// ----------------------------------------------------------------
`timescale 1ns/100ps
`include "wdg_regs.svh"
module mcu_watchdog_fail_counter
  import wdg_pkg::*;
#(
  parameter int STEP_CYC = `STEP_CYC,
  parameter int PULSE_CYC = `PULSE_MIN_CYC,
  parameter int RESET_HOLD_CYC = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // mcu pins
  input wire logic mcu_error_trigger_in_i,
  output logic mcu_reset_out_n_o,
  output logic power_stage_enable_out_o,
  // device state requests
  input wire logic go_active_i,
  input wire logic go_safe_i,
  input wire logic other_error_i,
  // configuration bits
  input wire logic [7:0] safety_function_config_i,
  input wire logic cfg_write_i,
  input wire logic drive_permit_bit_i,
  input wire logic [6:0] win1_steps_i,
  input wire logic [4:0] win2_steps_i,
  input wire logic win_cfg_write_i,
  input wire logic spi_frame_active_i,
  // qa mode events from the spi answer checker
  input wire logic qa_good_i,
  input wire logic qa_bad_i,
  // status
  input wire logic status_clear_i,
  output logic [7:0] watchdog_state_register_o,
  output logic [2:0] failure_tally_o,
  output logic out_of_range_o,
  output logic qa_mode_o,
  output logic [1:0] dev_state_o
);
  // refuse parameter values that the counters cannot hold
  initial begin
    if (RESET_HOLD_CYC < 1) $error("RESET_HOLD_CYC must be at least 1");
    if (RESET_HOLD_CYC > 65536) $error("RESET_HOLD_CYC must fit the hold counter");
    if (PULSE_CYC < 1) $error("PULSE_CYC must be at least 1");
    if (PULSE_CYC > 65534) $error("PULSE_CYC must fit the high-time counter");
    if (STEP_CYC < 1) $error("STEP_CYC must be at least 1");
  end

  // ----------------------------------------------------------------
  // saturating tally arithmetic
  // ----------------------------------------------------------------
  // both stop at their end points instead of wrapping
  function automatic logic [2:0] tally_up(input logic [2:0] t);
    tally_up = (t == `TALLY_MAX) ? t : t + 3'h1; // [RULE12]
  endfunction : tally_up

  function automatic logic [2:0] tally_down(input logic [2:0] t);
    tally_down = (t == 3'h0) ? t : t - 3'h1; // [RULE11]
  endfunction : tally_down

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  // device state and bookkeeping
  dev_state_e state_q;
  logic [2:0] tally_q;
  logic qa_mode_q;
  logic rst_permit_q;
  logic no_resp_q;
  logic early_q;
  logic [15:0] hold_q;

  // event and transition strobes
  logic trig_pulse;
  logic win_open;
  logic win_timeout;
  logic trig_good;
  logic trig_bad;
  logic good_ev;
  logic bad_ev;
  logic fail_ev;
  logic restart_seq;
  logic enter_diag;
  logic enter_active;
  logic enter_reset;
  logic permit_write;
  logic qa_good;
  logic qa_bad;
  logic tally_at_max;
  logic permit_rise;
  logic hold_done;

  // output shaping
  logic in_range;
  logic supervised;

  // ----------------------------------------------------------------
  // trigger qualification and window timing
  // ----------------------------------------------------------------
  // pin pulse qualifier; its strobe comes one cycle after the fall,
  // so a trigger is judged by the window it ends in
  trigger_filter #(
    .MIN_CYC(PULSE_CYC)
  ) u_filter (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .trig_i(mcu_error_trigger_in_i), // [RULE3]
    .trigger_o(trig_pulse)
  );

  // held in its first window while the device is in reset, so the
  // first sequence after reset starts from fresh counts
  window_timer #(
    .STEP_CYC(STEP_CYC)
  ) u_timer (
    .clock_i(clock_i),
    .srst_i(srst_i || state_q == DEV_RESET),
    .restart_i(restart_seq),
    .win1_steps_i(win1_steps_i),
    .win2_steps_i(win2_steps_i),
    .open_o(win_open),
    .timeout_o(win_timeout)
  );

  // ----------------------------------------------------------------
  // event classification
  // ----------------------------------------------------------------
  // closed window trigger: bad event, early flag, new sequence
  // open window trigger: good event, new sequence
  // window setting write: bad event and a new sequence
  // pin triggers count only in trigger mode, spi answers only in qa mode
  assign trig_good = !qa_mode_q && trig_pulse && win_open; // [RULE20]
  assign trig_bad = !qa_mode_q && trig_pulse && !win_open; // [RULE19]
  assign qa_good = qa_mode_q && qa_good_i; // [RULE4]
  assign qa_bad = qa_mode_q && qa_bad_i; // [RULE4]
  assign good_ev = trig_good || qa_good;
  assign bad_ev = trig_bad || qa_bad || win_cfg_write_i;
  assign fail_ev = bad_ev || win_timeout;
  assign restart_seq = good_ev || bad_ev; // timeout restarts itself

  // permit write and its 0 to 1 edge, and the tally ceiling
  assign permit_write = cfg_write_i && safety_function_config_i[`CFG_WATCHDOG_RESET_PERMIT_BIT];
  assign permit_rise = permit_write && !rst_permit_q;
  assign tally_at_max = (tally_q == `TALLY_MAX);

  // ----------------------------------------------------------------
  // state transitions
  // ----------------------------------------------------------------
  // reset request: a failure at seven with the permit set,
  // or the permit rising while the tally already sits at seven;
  // a reset request beats every other transition
  assign enter_reset = state_q != DEV_RESET &&
                       ((fail_ev && tally_at_max && rst_permit_q) || // [RULE15]
                        (permit_rise && tally_at_max)); // [RULE17]

  // reset is held a fixed number of cycles, then diagnostic
  assign hold_done = (hold_q == 16'(RESET_HOLD_CYC - 1));
  assign enter_diag = (state_q == DEV_RESET) && hold_done;

  // diagnostic to active on request, unless a reset wins
  assign enter_active = (state_q == DEV_DIAG) && go_active_i && !enter_reset;

  // ----------------------------------------------------------------
  // device state register
  // ----------------------------------------------------------------

  // device state and reset hold counter;
  // safe is left only through a block reset or a reset request
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q <= DEV_RESET;
      hold_q <= 16'h0000;
    end else if (enter_reset) begin
      state_q <= DEV_RESET;
      hold_q <= 16'h0000;
    end else begin
      case (state_q)
        DEV_RESET: begin
          hold_q <= hold_q + 16'h0001;
          if (enter_diag) state_q <= DEV_DIAG;
        end
        DEV_DIAG: begin
          if (go_safe_i) state_q <= DEV_SAFE;
          else if (enter_active) state_q <= DEV_ACTIVE;
        end
        DEV_ACTIVE: begin
          if (go_safe_i) state_q <= DEV_SAFE;
        end
        default: state_q <= DEV_SAFE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configuration bits
  // ----------------------------------------------------------------
  // mode select, writable only in diagnostic; reset clears it
  // a write in any other state leaves the mode as it is
  always_ff @(posedge clock_i) begin
    if (srst_i || state_q == DEV_RESET) qa_mode_q <= 1'b0; // [RULE2]
    else if (cfg_write_i && state_q == DEV_DIAG)
      qa_mode_q <= safety_function_config_i[`CFG_QA_MODE_BIT]; // [RULE5]
  end

  // watchdog reset permit, writable in any state;
  // kept through the reset state
  always_ff @(posedge clock_i) begin
    if (srst_i) rst_permit_q <= 1'b0;
    else if (cfg_write_i) rst_permit_q <= safety_function_config_i[`CFG_WATCHDOG_RESET_PERMIT_BIT];
  end

  // ----------------------------------------------------------------
  // failure tally
  // ----------------------------------------------------------------
  // priority, highest first:
  //   reset state or reset request: reload five
  //   diagnostic to active: reload five
  //   bad or timeout: one up, stop at seven
  //   good: one down, stop at zero
  // reinit beats events; permit bit plays no part here [RULE10]
  always_ff @(posedge clock_i) begin
    if (srst_i) tally_q <= `TALLY_INIT;
    else if (state_q == DEV_RESET || enter_reset) tally_q <= `TALLY_INIT; // [RULE16]
    else if (enter_active) tally_q <= `TALLY_INIT; // [RULE14] [RULE21]
    else if (fail_ev) tally_q <= tally_up(tally_q); // [RULE7] [RULE13]
    else if (good_ev) tally_q <= tally_down(tally_q); // [RULE7]
  end

  // ----------------------------------------------------------------
  // sticky status flags, set beats clear
  // ----------------------------------------------------------------
  // no-response flag: not latched while an spi frame is open,
  // though the tally still counts that timeout
  always_ff @(posedge clock_i) begin
    if (srst_i || state_q == DEV_RESET) no_resp_q <= 1'b0;
    else if (win_timeout && !spi_frame_active_i) no_resp_q <= 1'b1; // [RULE13]
    else if (status_clear_i) no_resp_q <= 1'b0;
  end

  // early-answer flag: trigger in the closed window
  always_ff @(posedge clock_i) begin
    if (srst_i || state_q == DEV_RESET) early_q <= 1'b0;
    else if (trig_bad) early_q <= 1'b1; // [RULE19]
    else if (status_clear_i) early_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // watchdog in range: tally four or less
  assign in_range = (tally_q < `TALLY_OUT_OF_RANGE); // [RULE9]
  // the stage may only run in diagnostic or active
  assign supervised = (state_q == DEV_DIAG) || (state_q == DEV_ACTIVE);

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  // both pins registered, so no decode glitch reaches the board
  logic power_stage_enable_out_q;
  logic mcu_reset_out_q;

  // drive enable only when in range and permitted;
  // it drops on the same edge as a reset request
  always_ff @(posedge clock_i) begin
    if (srst_i) power_stage_enable_out_q <= 1'b0;
    else power_stage_enable_out_q <= in_range && drive_permit_bit_i && // [RULE9]
                    !other_error_i && !enter_reset && supervised; // [RULE1] [RULE8]
  end

  // mcu reset low while in reset state,
  // and from the edge of a reset request
  always_ff @(posedge clock_i) begin
    if (srst_i) mcu_reset_out_q <= 1'b0;
    else mcu_reset_out_q <= !(enter_reset || (state_q == DEV_RESET && !enter_diag)); // [RULE15]
  end

  // levels handed straight out
  assign power_stage_enable_out_o = power_stage_enable_out_q;
  assign mcu_reset_out_n_o = mcu_reset_out_q;
  assign failure_tally_o = tally_q;
  assign out_of_range_o = (tally_q >= `TALLY_OUT_OF_RANGE); // [RULE8]
  assign qa_mode_o = qa_mode_q;
  assign dev_state_o = state_q;
  // status byte: bit 1 no response, bit 2 early answer, rest zero
  assign watchdog_state_register_o = {5'h00, early_q, no_resp_q, 1'b0};
endmodule : mcu_watchdog_fail_counter

// *** verification/mcu_model.sv ***
// mcu side model: trigger pulses on the error/trigger pin
`timescale 1ns/100ps
module mcu_model (
  // clock
  input wire logic clock_i,
  // trigger pin
  output logic trig_o
);
  initial trig_o = 1'b0;
  // high for len cycles, changed just after an edge
  task automatic pulse(input int len);
    @(posedge clock_i);
    trig_o <= 1'b1;
    repeat (len) @(posedge clock_i);
    trig_o <= 1'b0;
  endtask : pulse
  // answers over spi are given as qa pulses by the bench; no lockstep output
endmodule : mcu_model

// *** verification/mcu_watchdog_fail_counter_props.sv ***
// assertions on the watchdog failure tally block ports
`timescale 1ns/100ps
module mcu_watchdog_fail_counter_props
  import wdg_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // watched signals
  input wire logic other_error_i,
  input wire logic mcu_reset_out_n_o,
  input wire logic power_stage_enable_out_o,
  input wire logic [2:0] failure_tally_o,
  input wire logic out_of_range_o,
  input wire logic qa_mode_o,
  input wire logic [1:0] dev_state_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // ----------------------------------------
  // tally, enable and reset relations
  // ----------------------------------------
  chk_range_flag: assert property (out_of_range_o == (failure_tally_o >= 3'h5))
    else $error("range flag disagrees with tally");
  chk_oor_enable: assert property ($past(out_of_range_o) && out_of_range_o |->
    !power_stage_enable_out_o) else $error("enable high while out of range");
  chk_error_enable: assert property ($past(other_error_i) |-> !power_stage_enable_out_o)
    else $error("enable high during other error");
  chk_tally_step: assert property (dev_state_o == $past(dev_state_o) &&
    $changed(failure_tally_o) |-> ({1'b0, failure_tally_o} == {1'b0, $past(failure_tally_o)} + 4'h1)
    || ({1'b0, failure_tally_o} + 4'h1 == {1'b0, $past(failure_tally_o)}))
    else $error("tally moved by more than one");
  chk_reset_tally: assert property (dev_state_o == DEV_RESET |-> failure_tally_o == 3'h5)
    else $error("tally not five in reset");
  chk_reset_pin: assert property (dev_state_o == DEV_RESET |-> !mcu_reset_out_n_o)
    else $error("mcu reset high in reset state");
  chk_diag_entry: assert property ($past(dev_state_o) == DEV_RESET &&
    dev_state_o == DEV_DIAG |-> failure_tally_o == 3'h5 && !qa_mode_o)
    else $error("bad tally or mode on diagnostic entry");
  chk_active_load: assert property ($past(dev_state_o) == DEV_DIAG &&
    dev_state_o == DEV_ACTIVE |-> failure_tally_o == 3'h5) else $error("tally not five in active");
  chk_qa_change: assert property ($changed(qa_mode_o) |-> $past(dev_state_o) == DEV_DIAG
    || dev_state_o == DEV_RESET) else $error("mode changed outside diagnostic");
  // main scenarios reached
  cover property ($past(dev_state_o) != DEV_RESET && dev_state_o == DEV_RESET);
  cover property (failure_tally_o == 3'h0);
  cover property (failure_tally_o == 3'h7 && qa_mode_o);
  cover property (dev_state_o == DEV_ACTIVE && power_stage_enable_out_o);
endmodule : mcu_watchdog_fail_counter_props
bind mcu_watchdog_fail_counter mcu_watchdog_fail_counter_props props_i (.clock_i, .srst_i,
  .other_error_i, .mcu_reset_out_n_o, .power_stage_enable_out_o, .failure_tally_o,
  .out_of_range_o, .qa_mode_o, .dev_state_o);

// *** verification/mcu_watchdog_fail_counter_bench.sv ***
// self-checking bench for the watchdog failure tally block
`timescale 1ns/100ps
`include "wdg_regs.svh"
module mcu_watchdog_fail_counter_bench;
  import wdg_pkg::*;
  logic clock_i = 1'b0, srst_i = 1'b1, trig;
  logic go_active_i = 1'b0, other_error_i = 1'b0, cfg_write_i = 1'b0;
  logic win_cfg_write_i = 1'b0, qa_good_i = 1'b0, qa_bad_i = 1'b0, status_clear_i = 1'b0;
  logic drive_permit_bit_i = 1'b1, spi_frame_active_i = 1'b0;
  logic [7:0] safety_function_config_i = 8'h00, cv = 8'h00, watchdog_state_register_o;
  logic mcu_reset_out_n_o, power_stage_enable_out_o, out_of_range_o, qa_mode_o;
  logic [2:0] failure_tally_o;
  logic [1:0] dev_state_o;
  int n_fail = 0, checked = 0, cyc = 0, m = 5, k;
  // ----------------------------------------
  // clock, partner and design
  // ----------------------------------------
  always #25 clock_i = ~clock_i;
  mcu_model mcu_model_i (.clock_i, .trig_o(trig));
  mcu_watchdog_fail_counter #(.STEP_CYC(100), .PULSE_CYC(4)) mcu_watchdog_fail_counter_i (
    .clock_i, .srst_i, .mcu_error_trigger_in_i(trig), .mcu_reset_out_n_o,
    .power_stage_enable_out_o, .go_active_i, .go_safe_i(1'b0), .other_error_i,
    .safety_function_config_i, .cfg_write_i, .drive_permit_bit_i, .win1_steps_i(7'h02),
    .win2_steps_i(5'h1f), .win_cfg_write_i, .spi_frame_active_i, .qa_good_i, .qa_bad_i,
    .status_clear_i, .watchdog_state_register_o, .failure_tally_o, .out_of_range_o,
    .qa_mode_o, .dev_state_o);
  // ----------------------------------------
  // checks and drivers
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic settle;
    repeat (4) @(posedge clock_i);
    #1;
  endtask : settle
  // one-cycle pulse: 0 good, 1 bad, 2 window write, 3 config write, 4 status clear
  task automatic strobe(input int w);
    @(posedge clock_i);
    case (w)
      0: qa_good_i <= 1'b1;
      1: qa_bad_i <= 1'b1;
      2: win_cfg_write_i <= 1'b1;
      3: begin cfg_write_i <= 1'b1; safety_function_config_i <= cv; end
      default: status_clear_i <= 1'b1;
    endcase
    @(posedge clock_i);
    {qa_good_i, qa_bad_i, win_cfg_write_i, cfg_write_i, status_clear_i} <= 5'h00;
    settle();
  endtask : strobe
  // reference tally: saturating up and down count
  task automatic bump(input int w);
    m = (w == 0) ? ((m > 0) ? m - 1 : 0) : ((m < 7) ? m + 1 : 7);
  endtask : bump
  task automatic tally_cmp;
    chk("tally", 8'(m), {5'h00, failure_tally_o});
    chk("range", 8'(m >= 5), {7'h00, out_of_range_o});
  endtask : tally_cmp
  task automatic ev(input int w);
    strobe(w);
    bump(w);
    tally_cmp();
  endtask : ev
  task automatic trig_ev(input int len, input int w);
    mcu_model_i.pulse(len);
    settle();
    if (w >= 0) bump(w);
    tally_cmp();
  endtask : trig_ev
  task automatic wait_state(input logic [1:0] s);
    k = 0;
    while (dev_state_o !== s && k < 200) begin
      @(posedge clock_i);
      k++;
    end
    #1;
    chk("state", {6'h00, s}, {6'h00, dev_state_o});
  endtask : wait_state
  // hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    k = $urandom(32'h51e4b417);
    repeat (16) @(posedge clock_i);
    srst_i <= 1'b0;
    wait_state(DEV_DIAG);
    tally_cmp();
    chk("qa", 8'h00, {7'h00, qa_mode_o});
    ev(2);
    trig_ev(8, 1);
    chk("early", 8'h01, {7'h00, watchdog_state_register_o[`STAT_EARLY_BIT]});
    strobe(4);
    chk("clear", 8'h00, {7'h00, watchdog_state_register_o[`STAT_EARLY_BIT]});
    repeat (220) @(posedge clock_i);
    trig_ev(2, -1);
    trig_ev(8, 0);
    strobe(0);
    tally_cmp();
    cv = 8'h20;
    strobe(3);
    chk("qa", 8'h01, {7'h00, qa_mode_o});
    ev(2);
    for (int i = 0; i < 26; i++) ev(i < 7 ? 0 : i < 16 ? 1 : int'($urandom_range(1)));
    trig_ev(8, -1);
    @(posedge clock_i);
    go_active_i <= 1'b1;
    wait_state(DEV_ACTIVE);
    @(posedge clock_i);
    go_active_i <= 1'b0;
    m = 5;
    tally_cmp();
    chk("enable", 8'h00, {7'h00, power_stage_enable_out_o});
    ev(0);
    chk("enable", 8'h01, {7'h00, power_stage_enable_out_o});
    @(posedge clock_i);
    other_error_i <= 1'b1;
    settle();
    chk("enable", 8'h00, {7'h00, power_stage_enable_out_o});
    @(posedge clock_i);
    other_error_i <= 1'b0;
    drive_permit_bit_i <= 1'b0;
    settle();
    chk("enable", 8'h00, {7'h00, power_stage_enable_out_o});
    @(posedge clock_i);
    drive_permit_bit_i <= 1'b1;
    cv = 8'h00;
    strobe(3);
    chk("qa", 8'h01, {7'h00, qa_mode_o});
    ev(2);
    @(posedge clock_i);
    spi_frame_active_i <= 1'b1;
    for (int t = 0; t < 2; t++) begin
      k = 0;
      while (failure_tally_o === 3'(m) && k < 4000) begin
        @(posedge clock_i);
        k++;
      end
      #1;
      bump(1);
      tally_cmp();
      chk("timeout", 8'(t), {7'h00, watchdog_state_register_o[`STAT_NO_RESPONSE_BIT]});
      @(posedge clock_i);
      spi_frame_active_i <= 1'b0;
    end
    for (int i = 0; i < 3; i++) ev(1);
    chk("state", 8'(DEV_ACTIVE), {6'h00, dev_state_o});
    cv = 8'h08;
    strobe(3);
    chk("state", 8'(DEV_RESET), {6'h00, dev_state_o});
    chk("mcu_reset_out", 8'h00, {7'h00, mcu_reset_out_n_o});
    m = 5;
    tally_cmp();
    wait_state(DEV_DIAG);
    chk("qa", 8'h00, {7'h00, qa_mode_o});
    strobe(3);
    ev(2);
    ev(2);
    strobe(2);
    chk("state", 8'(DEV_RESET), {6'h00, dev_state_o});
    chk("mcu_reset_out", 8'h00, {7'h00, mcu_reset_out_n_o});
    close_out();
  end
endmodule : mcu_watchdog_fail_counter_bench
